/* hdl/vtf_pkg.sv */
// VLAN tag and port filter: register map, field layout, encodings.
// Assumes a 12-bit APB byte address and 32-bit data.
package vtf_pkg;
	localparam int          VTF_AW             = 12;
	localparam int          VTF_VID_W          = 12;
	localparam int          VTF_TIME_W         = 16;
	localparam int          VTF_TBL_DEPTH      = 64;
	localparam int          VTF_TBL_IW         = 6;
	localparam int          VTF_NAME_CHARS     = 12;
	localparam int          VTF_NAME_W         = 8 * VTF_NAME_CHARS;

	localparam logic [11:0] VTF_ADDR_CTRL      = 12'h000;
	localparam logic [11:0] VTF_ADDR_MGMT      = 12'h004;
	localparam logic [11:0] VTF_ADDR_ETYPE     = 12'h008;
	localparam logic [11:0] VTF_ADDR_JOIN      = 12'h00C;
	localparam logic [11:0] VTF_ADDR_LEAVE     = 12'h010;
	localparam logic [11:0] VTF_ADDR_LEAVEALL  = 12'h014;
	localparam logic [11:0] VTF_ADDR_TIDX      = 12'h020;
	localparam logic [11:0] VTF_ADDR_TCMD      = 12'h024;
	localparam logic [11:0] VTF_ADDR_TVID      = 12'h028;
	localparam logic [11:0] VTF_ADDR_TEG       = 12'h02C;
	localparam logic [11:0] VTF_ADDR_TNAME0    = 12'h030;
	localparam logic [11:0] VTF_ADDR_TNAME1    = 12'h034;
	localparam logic [11:0] VTF_ADDR_TNAME2    = 12'h038;
	localparam logic [11:0] VTF_ADDR_PORT_BASE = 12'h040;

	// Port config word
	localparam int          VTF_PC_TUN_LSB     = 12;
	localparam int          VTF_PC_ACC_BIT     = 16;
	localparam int          VTF_PC_IFLT_BIT    = 17;
	localparam int          VTF_PC_GVRP_BIT    = 18;
	// Table VID word
	localparam int          VTF_TV_PV_LSB      = 12;
	localparam int          VTF_TV_ST_LSB      = 16;
	localparam int          VTF_TV_USED_BIT    = 31;

	localparam logic [11:0] VTF_VID_RSVD_LO    = 12'h000;
	localparam logic [11:0] VTF_VID_RSVD_HI    = 12'hFFF;
	localparam logic [11:0] VTF_VID_DEFAULT    = 12'h001;
	localparam logic [15:0] VTF_TPID_CTAG      = 16'h8100;
	localparam logic [15:0] VTF_ETYPE_RST      = 16'h88A8;
	localparam logic [15:0] VTF_JOIN_RST       = 16'h0014;
	localparam logic [15:0] VTF_LEAVE_RST      = 16'h003C;
	localparam logic [15:0] VTF_LEAVEALL_RST   = 16'h03E8;
	localparam logic [31:0] VTF_NAME_PREFIX    = 32'h564C414E;
	localparam logic [7:0]  VTF_ASCII_ZERO     = 8'h30;

	localparam logic [1:0]  VTF_EG_NONE        = 2'h0;
	localparam logic [1:0]  VTF_EG_UNTAG       = 2'h1;
	localparam logic [1:0]  VTF_EG_TAG         = 2'h2;
	localparam logic [1:0]  VTF_TUN_NONE       = 2'h0;
	localparam logic [1:0]  VTF_TUN_ACCESS     = 2'h1;
	localparam logic [1:0]  VTF_TUN_UPLINK     = 2'h2;
	localparam logic        VTF_ACC_ALL        = 1'b0;
	localparam logic        VTF_ACC_TAGONLY    = 1'b1;
	localparam logic [1:0]  VTF_PV_NONE        = 2'h0;
	localparam logic [1:0]  VTF_PV_PRIMARY     = 2'h1;
	localparam logic [1:0]  VTF_PV_ISOLATED    = 2'h2;
	localparam logic [1:0]  VTF_PV_COMMUNITY   = 2'h3;
	localparam logic [1:0]  VTF_ST_UNUSED      = 2'h0;
	localparam logic [1:0]  VTF_ST_STATIC      = 2'h1;
	localparam logic [1:0]  VTF_ST_DYNAMIC     = 2'h2;
	localparam logic [1:0]  VTF_CMD_WRITE      = 2'h1;
	localparam logic [1:0]  VTF_CMD_REMOVE     = 2'h2;
endpackage

/* hdl/vtf_vlan_tag_port_filter.sv */
// VLAN classification, tag push/pop decisions, static VLAN table and GVRP timers.
// Assumes frame descriptors and GVRP events come from logic on pclk; APB slave, no waits.
// How it works
// - Port default VID; 0 and 4095 refused, reset 1
// - Per-port tunnel mode: none, access, uplink
// - Access port pushes outer tag with default VID on tagged frames
// - Access port strips outer tag on egress
// - Uplink port keeps outer service tag
// - Programmable outer tag EtherType
// - Admit-all accepts tagged and untagged frames
// - Tagged-only drops untagged received frames
// - Ingress filter drops frames from non-member ports
// - Management VLAN gates CPU-bound frames, reset 1
// - Table VIDs 1 to 4094; VLAN 1 present
// - Twelve-character name, default VLAN plus VID
// - At most 64 table entries
// - Entry status unused, static or dynamic
// - Per-VLAN per-port egress: none, untag, tag
// - Isolated private VLAN type restricts forwarding
// - GVRP needs global and port enable
// - Per-port join timer paces join messages
// - Leave timer releases leaving registrations
// - Per-port leave-all timer ages dynamic VLANs
`timescale 1ns/1ps
module vtf_vlan_tag_port_filter #(
	parameter int NP = 8,
	parameter int PW = $clog2(NP)
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [vtf_pkg::VTF_AW-1:0]   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         rx_valid,
	input  wire logic [PW-1:0]                rx_port,
	input  wire logic                         rx_tagged,
	input  wire logic [vtf_pkg::VTF_VID_W-1:0] rx_vid,
	input  wire logic                         rx_to_cpu,
	output logic                              cls_valid,
	output logic                              cls_drop,
	output logic      [vtf_pkg::VTF_VID_W-1:0] cls_vid,
	output logic                              cls_push,
	output logic      [15:0]                  cls_tpid,
	output logic                              cls_cpu,
	input  wire logic                         tx_valid,
	input  wire logic [PW-1:0]                tx_port,
	input  wire logic [PW-1:0]                tx_src_port,
	input  wire logic [vtf_pkg::VTF_VID_W-1:0] tx_vid,
	input  wire logic                         tx_outer,
	output logic                              eg_valid,
	output logic                              eg_fwd,
	output logic                              eg_strip,
	output logic                              eg_tag,
	output logic      [15:0]                  eg_tpid,
	input  wire logic                         gv_valid,
	input  wire logic [PW-1:0]                gv_port,
	input  wire logic                         gv_join,
	input  wire logic [vtf_pkg::VTF_VID_W-1:0] gv_vid,
	output logic      [NP-1:0]                gv_join_tick,
	output logic      [NP-1:0]                gv_leaveall_tick
);
	import vtf_pkg::*;

	localparam int DEP = VTF_TBL_DEPTH;

	generate
		if (NP < 2 || NP > 16 || PW != $clog2(NP)) begin : g_bad
			$error("vtf: NP must be 2..16 and PW must be clog2(NP)");
		end
	endgenerate

	typedef struct packed {
		logic [VTF_VID_W-1:0]  port_default_vid;
		logic [1:0]            tun;
		logic                  acc;
		logic                  iflt;
		logic                  gvrp;
		logic [VTF_TIME_W-1:0] join_cnt;
		logic [VTF_TIME_W-1:0] la_cnt;
	} vtf_port_t;

	typedef struct packed {
		logic                  used;
		logic                  dyn;
		logic                  lv;
		logic [VTF_VID_W-1:0]  vid;
		logic [1:0]            pv;
		logic [2*NP-1:0]       eg;
		logic [VTF_NAME_W-1:0] name;
		logic [VTF_TIME_W-1:0] lv_cnt;
	} vtf_entry_t;

	typedef struct packed {
		logic                  gvrp_en;
		logic [VTF_VID_W-1:0]  mgmt_vid;
		logic [15:0]           etype;
		logic [VTF_TIME_W-1:0] join_t;
		logic [VTF_TIME_W-1:0] leave_t;
		logic [VTF_TIME_W-1:0] la_t;
		logic [VTF_TBL_IW-1:0] idx;
		logic                  cmd_err;
		logic [VTF_VID_W-1:0]  st_vid;
		logic [1:0]            st_pv;
		logic [2*NP-1:0]       st_eg;
		logic [VTF_NAME_W-1:0] st_name;
		logic [31:0]           prdata;
		logic                  cls_valid;
		logic                  cls_drop;
		logic [VTF_VID_W-1:0]  cls_vid;
		logic                  cls_push;
		logic [15:0]           cls_tpid;
		logic                  cls_cpu;
		logic                  eg_valid;
		logic                  eg_fwd;
		logic                  eg_strip;
		logic                  eg_tag;
		logic [15:0]           eg_tpid;
		logic [NP-1:0]         join_tick;
		logic [NP-1:0]         la_tick;
		vtf_port_t [NP-1:0]    port;
		vtf_entry_t [DEP-1:0]  tbl;
	} vtf_state_t;

	vtf_state_t st;
	vtf_state_t next_st;

	function automatic logic [VTF_NAME_W-1:0] vtf_def_name(input logic [VTF_VID_W-1:0] v);
		logic [3:0]            d3;
		logic [3:0]            d2;
		logic [3:0]            d1;
		logic [3:0]            d0;
		logic [VTF_NAME_W-1:0] n;
		int                    k;
		d3 = 4'(v / 1000);
		d2 = 4'((v / 100) % 10);
		d1 = 4'((v / 10) % 10);
		d0 = 4'(v % 10);
		n = {VTF_NAME_PREFIX, {(VTF_NAME_W - 32){1'b0}}};
		k = 4;
		if (d3 != 4'h0) begin
			n[VTF_NAME_W-1-8*k -: 8] = VTF_ASCII_ZERO + {4'h0, d3};
			k = k + 1;
		end
		if (v >= 12'd100) begin
			n[VTF_NAME_W-1-8*k -: 8] = VTF_ASCII_ZERO + {4'h0, d2};
			k = k + 1;
		end
		if (v >= 12'd10) begin
			n[VTF_NAME_W-1-8*k -: 8] = VTF_ASCII_ZERO + {4'h0, d1};
			k = k + 1;
		end
		n[VTF_NAME_W-1-8*k -: 8] = VTF_ASCII_ZERO + {4'h0, d0};
		return n;
	endfunction

	// Lowest set bit: {found, index}
	function automatic logic [VTF_TBL_IW:0] vtf_first(input logic [DEP-1:0] v);
		logic [VTF_TBL_IW:0] r;
		r = '0;
		for (int i = DEP - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, VTF_TBL_IW'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic vtf_member(input logic [1:0] rule);
		return (rule == VTF_EG_UNTAG) || (rule == VTF_EG_TAG);
	endfunction

	// Ingress lookup
	logic [PW-1:0]         rx_pi;
	logic                  rx_pok;
	vtf_port_t             rx_pc;
	logic [VTF_VID_W-1:0]  rx_cvid;
	logic [DEP-1:0]        hit_rx;
	logic [DEP-1:0]        hit_mg;
	logic [VTF_TBL_IW:0]   rx_f;
	logic [VTF_TBL_IW:0]   mg_f;
	logic                  rx_mem;
	logic                  mg_mem;
	// Egress lookup
	logic [PW-1:0]         tx_pi;
	logic [PW-1:0]         tx_si;
	logic                  tx_pok;
	logic [DEP-1:0]        hit_tx;
	logic [VTF_TBL_IW:0]   tx_f;
	logic                  tx_mem;
	logic                  tx_src_mem;
	logic [1:0]            tx_rule;
	logic [1:0]            tx_tun;
	// GVRP and software table access
	logic [PW-1:0]         gv_pi;
	logic                  gv_act;
	logic [DEP-1:0]        hit_gv;
	logic [DEP-1:0]        hit_sw;
	logic [DEP-1:0]        free_e;
	logic [VTF_TBL_IW:0]   gv_f;
	logic [VTF_TBL_IW:0]   fr_f;
	logic [VTF_TBL_IW:0]   sw_f;
	// APB decode
	logic [11:0]           a_off;
	logic                  port_sel;
	logic [PW-1:0]         a_pi;
	logic                  fixed_sel;
	logic                  apb_wr;
	logic                  port_default_vid_bad;
	vtf_entry_t            cur_e;

	assign rx_pok = int'(rx_port) < NP;
	assign rx_pi  = rx_pok ? rx_port : '0;
	assign rx_pc  = st.port[rx_pi];
	assign rx_cvid = (rx_tagged && rx_pc.tun != VTF_TUN_ACCESS) ? rx_vid : rx_pc.port_default_vid;
	assign tx_pok = (int'(tx_port) < NP) && (int'(tx_src_port) < NP);
	assign tx_pi  = tx_pok ? tx_port : '0;
	assign tx_si  = tx_pok ? tx_src_port : '0;
	assign gv_pi  = (int'(gv_port) < NP) ? gv_port : '0;
	assign gv_act = gv_valid && (int'(gv_port) < NP) && st.gvrp_en && st.port[gv_pi].gvrp;

	genvar e;
	generate
		for (e = 0; e < DEP; e++) begin : g_hit
			assign hit_rx[e] = st.tbl[e].used && (st.tbl[e].vid == rx_cvid);
			assign hit_mg[e] = st.tbl[e].used && (st.tbl[e].vid == st.mgmt_vid);
			assign hit_tx[e] = st.tbl[e].used && (st.tbl[e].vid == tx_vid);
			assign hit_gv[e] = st.tbl[e].used && (st.tbl[e].vid == gv_vid);
			assign hit_sw[e] = st.tbl[e].used && (st.tbl[e].vid == st.st_vid)
				&& (VTF_TBL_IW'(e) != st.idx);
			assign free_e[e] = !st.tbl[e].used;
		end
	endgenerate

	assign rx_f   = vtf_first(hit_rx);
	assign mg_f   = vtf_first(hit_mg);
	assign tx_f   = vtf_first(hit_tx);
	assign gv_f   = vtf_first(hit_gv);
	assign fr_f   = vtf_first(free_e);
	assign sw_f   = vtf_first(hit_sw);
	assign rx_mem = rx_f[VTF_TBL_IW]
		&& vtf_member(st.tbl[rx_f[VTF_TBL_IW-1:0]].eg[2*rx_pi +: 2]);
	assign mg_mem = mg_f[VTF_TBL_IW]
		&& vtf_member(st.tbl[mg_f[VTF_TBL_IW-1:0]].eg[2*rx_pi +: 2]);
	assign tx_rule = tx_f[VTF_TBL_IW] ? st.tbl[tx_f[VTF_TBL_IW-1:0]].eg[2*tx_pi +: 2]
		: VTF_EG_NONE;
	assign tx_mem = vtf_member(tx_rule);
	assign tx_src_mem = tx_f[VTF_TBL_IW]
		&& vtf_member(st.tbl[tx_f[VTF_TBL_IW-1:0]].eg[2*tx_si +: 2]);
	assign tx_tun = st.port[tx_pi].tun;

	assign a_off     = paddr - VTF_ADDR_PORT_BASE;
	assign port_sel  = (paddr >= VTF_ADDR_PORT_BASE) && (int'(a_off[11:2]) < NP)
		&& (a_off[1:0] == 2'h0);
	assign a_pi      = a_off[PW+1:2];
	assign fixed_sel = (paddr == VTF_ADDR_CTRL) || (paddr == VTF_ADDR_MGMT)
		|| (paddr == VTF_ADDR_ETYPE) || (paddr == VTF_ADDR_JOIN)
		|| (paddr == VTF_ADDR_LEAVE) || (paddr == VTF_ADDR_LEAVEALL)
		|| (paddr == VTF_ADDR_TIDX) || (paddr == VTF_ADDR_TCMD)
		|| (paddr == VTF_ADDR_TVID) || (paddr == VTF_ADDR_TEG)
		|| (paddr == VTF_ADDR_TNAME0) || (paddr == VTF_ADDR_TNAME1)
		|| (paddr == VTF_ADDR_TNAME2);
	assign port_default_vid_bad  = (pwdata[VTF_VID_W-1:0] == VTF_VID_RSVD_LO)
		|| (pwdata[VTF_VID_W-1:0] == VTF_VID_RSVD_HI);
	assign apb_wr    = psel && penable && pwrite;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && (!(port_sel || fixed_sel)
		|| (pwrite && port_sel && port_default_vid_bad));
	assign cur_e     = st.tbl[st.idx];

	always_comb begin
		next_st = st;
		// GVRP port timers
		for (int p = 0; p < NP; p++) begin
			next_st.join_tick[p] = 1'b0;
			next_st.la_tick[p]   = 1'b0;
			if (st.gvrp_en && st.port[p].gvrp) begin
				if (st.port[p].join_cnt >= st.join_t) begin
					next_st.join_tick[p]     = 1'b1;
					next_st.port[p].join_cnt = '0;
				end else begin
					next_st.port[p].join_cnt = st.port[p].join_cnt + 16'h0001;
				end
				if (st.port[p].la_cnt >= st.la_t) begin
					next_st.la_tick[p]     = 1'b1;
					next_st.port[p].la_cnt = '0;
				end else begin
					next_st.port[p].la_cnt = st.port[p].la_cnt + 16'h0001;
				end
			end else begin
				next_st.port[p].join_cnt = '0;
				next_st.port[p].la_cnt   = '0;
			end
		end
		// Leave timers and leave-all aging of dynamic entries
		for (int i = 0; i < DEP; i++) begin
			if (st.tbl[i].lv) begin
				if (st.tbl[i].lv_cnt >= st.leave_t) begin
					next_st.tbl[i] = '0;
				end else begin
					next_st.tbl[i].lv_cnt = st.tbl[i].lv_cnt + 16'h0001;
				end
			end else if ((|st.la_tick) && st.tbl[i].used && st.tbl[i].dyn) begin
				next_st.tbl[i].lv     = 1'b1;
				next_st.tbl[i].lv_cnt = '0;
			end
		end
		// GVRP registration events
		if (gv_act && gv_f[VTF_TBL_IW]) begin
			if (st.tbl[gv_f[VTF_TBL_IW-1:0]].dyn) begin
				if (gv_join) begin
					next_st.tbl[gv_f[VTF_TBL_IW-1:0]].lv = 1'b0;
					next_st.tbl[gv_f[VTF_TBL_IW-1:0]].lv_cnt = '0;
					next_st.tbl[gv_f[VTF_TBL_IW-1:0]].eg[2*gv_pi +: 2] = VTF_EG_TAG;
				end else begin
					next_st.tbl[gv_f[VTF_TBL_IW-1:0]].lv = 1'b1;
					next_st.tbl[gv_f[VTF_TBL_IW-1:0]].lv_cnt = '0;
				end
			end
		end else if (gv_act && gv_join && fr_f[VTF_TBL_IW]
				&& gv_vid != VTF_VID_RSVD_LO && gv_vid != VTF_VID_RSVD_HI) begin
			next_st.tbl[fr_f[VTF_TBL_IW-1:0]] = '0;
			next_st.tbl[fr_f[VTF_TBL_IW-1:0]].used = 1'b1;
			next_st.tbl[fr_f[VTF_TBL_IW-1:0]].dyn  = 1'b1;
			next_st.tbl[fr_f[VTF_TBL_IW-1:0]].vid  = gv_vid;
			next_st.tbl[fr_f[VTF_TBL_IW-1:0]].name = vtf_def_name(gv_vid);
			next_st.tbl[fr_f[VTF_TBL_IW-1:0]].eg[2*gv_pi +: 2] = VTF_EG_TAG;
		end
		// Ingress classification
		next_st.cls_valid = rx_valid;
		next_st.cls_vid   = rx_cvid;
		next_st.cls_drop  = rx_valid && (!rx_pok
			|| (rx_pc.acc == VTF_ACC_TAGONLY && !rx_tagged)
			|| (rx_pc.iflt && !rx_mem)
			|| (rx_to_cpu && !mg_mem));
		next_st.cls_cpu   = rx_valid && rx_to_cpu && mg_mem;
		next_st.cls_push  = rx_valid && rx_tagged && rx_pc.tun == VTF_TUN_ACCESS;
		next_st.cls_tpid  = st.etype;
		// Egress decision
		next_st.eg_valid = tx_valid;
		next_st.eg_fwd   = tx_valid && tx_pok && tx_mem
			&& !(st.tbl[tx_f[VTF_TBL_IW-1:0]].pv == VTF_PV_ISOLATED
			&& tx_src_mem && tx_si != tx_pi);
		next_st.eg_strip = tx_valid && tx_tun == VTF_TUN_ACCESS && tx_outer;
		if (tx_tun == VTF_TUN_UPLINK && tx_outer) begin
			next_st.eg_tag  = tx_valid;
			next_st.eg_tpid = st.etype;
		end else if (tx_tun == VTF_TUN_ACCESS) begin
			next_st.eg_tag  = 1'b0;
			next_st.eg_tpid = VTF_TPID_CTAG;
		end else begin
			next_st.eg_tag  = tx_valid && tx_rule == VTF_EG_TAG;
			next_st.eg_tpid = (tx_tun == VTF_TUN_UPLINK) ? st.etype : VTF_TPID_CTAG;
		end
		// APB read data, captured in the setup cycle
		if (psel && !penable && !pwrite) begin
			next_st.prdata = '0;
			if (port_sel) begin
				next_st.prdata[VTF_VID_W-1:0] = st.port[a_pi].port_default_vid;
				next_st.prdata[VTF_PC_TUN_LSB +: 2] = st.port[a_pi].tun;
				next_st.prdata[VTF_PC_ACC_BIT]  = st.port[a_pi].acc;
				next_st.prdata[VTF_PC_IFLT_BIT] = st.port[a_pi].iflt;
				next_st.prdata[VTF_PC_GVRP_BIT] = st.port[a_pi].gvrp;
			end
			unique case (paddr)
				VTF_ADDR_CTRL:     next_st.prdata[0] = st.gvrp_en;
				VTF_ADDR_MGMT:     next_st.prdata[VTF_VID_W-1:0] = st.mgmt_vid;
				VTF_ADDR_ETYPE:    next_st.prdata[15:0] = st.etype;
				VTF_ADDR_JOIN:     next_st.prdata[15:0] = st.join_t;
				VTF_ADDR_LEAVE:    next_st.prdata[15:0] = st.leave_t;
				VTF_ADDR_LEAVEALL: next_st.prdata[15:0] = st.la_t;
				VTF_ADDR_TIDX:     next_st.prdata[VTF_TBL_IW-1:0] = st.idx;
				VTF_ADDR_TCMD:     next_st.prdata[0] = st.cmd_err;
				VTF_ADDR_TVID: begin
					next_st.prdata[VTF_VID_W-1:0] = cur_e.vid;
					next_st.prdata[VTF_TV_PV_LSB +: 2] = cur_e.pv;
					next_st.prdata[VTF_TV_USED_BIT] = cur_e.used;
					next_st.prdata[VTF_TV_ST_LSB +: 2] = !cur_e.used ? VTF_ST_UNUSED
						: cur_e.dyn ? VTF_ST_DYNAMIC
						: (|cur_e.eg) ? VTF_ST_STATIC : VTF_ST_UNUSED;
				end
				VTF_ADDR_TEG:      next_st.prdata[2*NP-1:0] = cur_e.eg;
				VTF_ADDR_TNAME0:   next_st.prdata = cur_e.name[95:64];
				VTF_ADDR_TNAME1:   next_st.prdata = cur_e.name[63:32];
				VTF_ADDR_TNAME2:   next_st.prdata = cur_e.name[31:0];
				default:           ;
			endcase
		end
		// APB writes
		if (apb_wr && port_sel && !port_default_vid_bad) begin
			next_st.port[a_pi].port_default_vid = pwdata[VTF_VID_W-1:0];
			next_st.port[a_pi].tun  = pwdata[VTF_PC_TUN_LSB +: 2];
			next_st.port[a_pi].acc  = pwdata[VTF_PC_ACC_BIT];
			next_st.port[a_pi].iflt = pwdata[VTF_PC_IFLT_BIT];
			next_st.port[a_pi].gvrp = pwdata[VTF_PC_GVRP_BIT];
		end
		if (apb_wr) begin
			unique case (paddr)
				VTF_ADDR_CTRL:     next_st.gvrp_en = pwdata[0];
				VTF_ADDR_MGMT:     next_st.mgmt_vid = pwdata[VTF_VID_W-1:0];
				VTF_ADDR_ETYPE:    next_st.etype = pwdata[15:0];
				VTF_ADDR_JOIN:     next_st.join_t = pwdata[15:0];
				VTF_ADDR_LEAVE:    next_st.leave_t = pwdata[15:0];
				VTF_ADDR_LEAVEALL: next_st.la_t = pwdata[15:0];
				VTF_ADDR_TIDX:     next_st.idx = pwdata[VTF_TBL_IW-1:0];
				VTF_ADDR_TVID: begin
					next_st.st_vid = pwdata[VTF_VID_W-1:0];
					next_st.st_pv  = pwdata[VTF_TV_PV_LSB +: 2];
				end
				VTF_ADDR_TEG:      next_st.st_eg = pwdata[2*NP-1:0];
				VTF_ADDR_TNAME0:   next_st.st_name[95:64] = pwdata;
				VTF_ADDR_TNAME1:   next_st.st_name[63:32] = pwdata;
				VTF_ADDR_TNAME2:   next_st.st_name[31:0] = pwdata;
				VTF_ADDR_TCMD: begin
					if (pwdata[1:0] == VTF_CMD_WRITE) begin
						if (st.st_vid == VTF_VID_RSVD_LO || st.st_vid == VTF_VID_RSVD_HI
								|| sw_f[VTF_TBL_IW]) begin
							next_st.cmd_err = 1'b1;
						end else begin
							next_st.cmd_err = 1'b0;
							next_st.tbl[st.idx] = '0;
							next_st.tbl[st.idx].used = 1'b1;
							next_st.tbl[st.idx].vid  = st.st_vid;
							next_st.tbl[st.idx].pv   = st.st_pv;
							next_st.tbl[st.idx].eg   = st.st_eg;
							next_st.tbl[st.idx].name = (st.st_name == '0)
								? vtf_def_name(st.st_vid) : st.st_name;
						end
					end else if (pwdata[1:0] == VTF_CMD_REMOVE) begin
						if (cur_e.used && cur_e.vid == VTF_VID_DEFAULT) begin
							next_st.cmd_err = 1'b1;
						end else begin
							next_st.cmd_err = 1'b0;
							next_st.tbl[st.idx] = '0;
						end
					end
				end
				default:           ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.mgmt_vid <= VTF_VID_DEFAULT;
			st.etype    <= VTF_ETYPE_RST;
			st.join_t   <= VTF_JOIN_RST;
			st.leave_t  <= VTF_LEAVE_RST;
			st.la_t     <= VTF_LEAVEALL_RST;
			st.eg_tpid  <= VTF_TPID_CTAG;
			st.cls_tpid <= VTF_ETYPE_RST;
			st.tbl[0].used <= 1'b1;
			st.tbl[0].vid  <= VTF_VID_DEFAULT;
			st.tbl[0].name <= {VTF_NAME_PREFIX, VTF_ASCII_ZERO + 8'h01, 56'h0};
			for (int p = 0; p < NP; p++) begin
				st.port[p].port_default_vid <= VTF_VID_DEFAULT;
				st.tbl[0].eg[2*p +: 2] <= VTF_EG_UNTAG;
			end
		end else begin
			st <= next_st;
		end
	end

	assign prdata           = st.prdata;
	assign cls_valid        = st.cls_valid;
	assign cls_drop         = st.cls_drop;
	assign cls_vid          = st.cls_vid;
	assign cls_push         = st.cls_push;
	assign cls_tpid         = st.cls_tpid;
	assign cls_cpu          = st.cls_cpu;
	assign eg_valid         = st.eg_valid;
	assign eg_fwd           = st.eg_fwd;
	assign eg_strip         = st.eg_strip;
	assign eg_tag           = st.eg_tag;
	assign eg_tpid          = st.eg_tpid;
	assign gv_join_tick     = st.join_tick;
	assign gv_leaveall_tick = st.la_tick;
endmodule

/* test/vtf_properties.sv */
// Checker on the filter's ports.
// Assumes a bind from the bench top.
`timescale 1ns/1ps
module vtf_properties (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pslverr,
	input wire logic        rx_valid,
	input wire logic        rx_tagged,
	input wire logic [11:0] rx_vid,
	input wire logic        cls_valid,
	input wire logic [11:0] cls_vid,
	input wire logic        cls_push,
	input wire logic        tx_valid,
	input wire logic        tx_outer,
	input wire logic        eg_valid,
	input wire logic        eg_strip,
	input wire logic        eg_tag
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	in_lat_a: assert property (rx_valid |=> cls_valid) else $error("late");
	in_idle_a: assert property (!rx_valid |=> !cls_valid) else $error("spurious");
	eg_lat_a: assert property (tx_valid |=> eg_valid) else $error("eg late");
	push_tag_a: assert property (cls_push |-> $past(rx_tagged)) else $error("push");
	tag_vid_a: assert property (cls_valid && $past(rx_tagged) && !cls_push
		|-> cls_vid == $past(rx_vid)) else $error("vid");
	strip_a: assert property (eg_strip |-> $past(tx_outer)) else $error("strip");
	strip_untag_a: assert property (eg_strip |-> !eg_tag) else $error("tag");
	err_phase_a: assert property (pslverr |-> psel && penable) else $error("err");
endmodule

/* test/vtf_port_model.sv */
// Ingress port model: one frame descriptor per request.
// Assumes requests change just after a rising edge.
`timescale 1ns/1ps
module vtf_port_model (
	input  wire logic        send,
	input  wire logic [2:0]  s_port,
	input  wire logic        s_tag,
	input  wire logic [11:0] s_vid,
	output logic             rx_valid,
	output logic [2:0]       rx_port,
	output logic             rx_tagged,
	output logic [11:0]      rx_vid
);
	// Idle lines show the inverse of the last frame
	always_comb begin
		rx_valid = send;
		rx_port = send ? s_port : ~s_port;
		rx_tagged = send ? s_tag : ~s_tag;
		rx_vid = send ? s_vid : ~s_vid;
	end
endmodule

/* test/vlan_tag_port_filter_test.sv */
// Bench: random port setup, ingress and egress against a model.
// Assumes NP of 8.
`timescale 1ns/1ps
module vlan_tag_port_filter_test;
	import vtf_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic        send = 0, s_tag = 0, rx_to_cpu = 0, tx_valid = 0, tx_outer = 0, rx_valid;
	logic        rx_tagged, cls_valid, cls_drop, cls_push, cls_cpu, eg_valid, eg_fwd;
	logic        eg_strip, eg_tag, gv_valid = 0;
	logic [7:0]  gv_join_tick, gv_leaveall_tick;
	logic [11:0] paddr = 0, s_vid = 0, tx_vid = 1, cls_vid, rx_vid;
	logic [31:0] pwdata = 0, prdata, rd, rs = 32'h2DB7;
	logic [2:0]  s_port = 0, tx_port = 0, tx_src_port = 0, rx_port;
	logic [15:0] cls_tpid, eg_tpid, et = 16'h88A8;
	int          n_mismatch = 0, samples_checked = 0, mg = 1, n = 0, m = 0;
	int          pv[8] = '{default: 1}, tn[8], ac[8], fl[8];
	vtf_port_model pm (.send, .s_port, .s_tag, .s_vid, .rx_valid, .rx_port, .rx_tagged, .rx_vid);
	vtf_vlan_tag_port_filter #(.NP(8)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_port, .rx_tagged, .rx_vid,
		.rx_to_cpu, .cls_valid, .cls_drop, .cls_vid, .cls_push, .cls_tpid, .cls_cpu, .tx_valid,
		.tx_port, .tx_src_port, .tx_vid, .tx_outer, .eg_valid, .eg_fwd, .eg_strip, .eg_tag,
		.eg_tpid, .gv_valid, .gv_port(3'h3), .gv_join(1'b1), .gv_vid(12'h005),
		.gv_join_tick, .gv_leaveall_tick);
	always #12.5 pclk = ~pclk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			n_mismatch++;
			summarize();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wport(input int p, input int v);
		logic bad;
		bad = (v == 0 || v == 4095);
		rs = lfsr(rs);
		apb(1, VTF_ADDR_PORT_BASE + 12'(4 * p), 32'(v) | 32'(p % 3) << 12 | rs & 32'h0003_0000);
		chk("pslverr", 32'(bad), er);
		if (!bad) begin
			pv[p] = v;
			tn[p] = p % 3;
			ac[p] = rs[16];
			fl[p] = rs[17];
		end
	endtask
	task automatic rx(input int p, input logic t, input logic [11:0] v, input logic c);
		int ev;
		ev = (t && tn[p] != 1) ? v : pv[p];
		@(posedge pclk);
		s_port <= 3'(p);
		s_tag <= t;
		s_vid <= v;
		rx_to_cpu <= c;
		send <= 1;
		@(posedge pclk);
		send <= 0;
		#1;
		chk("cls_vid", ev, cls_vid);
		chk("cls_push", 32'(t && tn[p] == 1), cls_push);
		chk("cls_tpid", et, cls_tpid);
		chk("cls_drop", 32'(ac[p] && !t || fl[p] && ev != 1 || c && mg != 1), cls_drop);
		chk("cls_cpu", 32'(c && mg == 1), cls_cpu);
	endtask
	task automatic tx(input int p, input logic o);
		@(posedge pclk);
		tx_port <= 3'(p);
		tx_outer <= o;
		tx_valid <= 1;
		@(posedge pclk);
		tx_valid <= 0;
		#1;
		chk("eg_fwd", 1, eg_fwd);
		chk("eg_strip", 32'(tn[p] == 1 && o), eg_strip);
		chk("eg_tag", 32'(tn[p] == 2), eg_tag);
		if (tn[p] == 2)
			chk("eg_tpid", et, eg_tpid);
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		rdc_all: begin
			apb(0, VTF_ADDR_MGMT, 0);
			chk("mgmt", 1, rd);
			apb(0, VTF_ADDR_TVID, 0);
			chk("tvid", 32'h8001_0001, rd);
			apb(0, 12'hFFC, 0);
			chk("pslverr", 1, er);
		end
		rs = lfsr(rs);
		et = rs[15:0];
		apb(1, VTF_ADDR_ETYPE, 32'(et));
		for (int p = 0; p < 8; p++) begin
			rs = lfsr(rs);
			wport(p, p == 0 ? 0 : p == 1 ? 4095 : 2 + rs % 4093);
		end
		rd = 0;
		for (int p = 0; p < 8; p++)
			rd |= 32'(tn[p] == 2 ? 2 : 1) << 2 * p;
		apb(1, VTF_ADDR_TEG, rd);
		apb(1, VTF_ADDR_TVID, 1);
		apb(1, VTF_ADDR_TCMD, 32'(VTF_CMD_WRITE));
		apb(0, VTF_ADDR_TCMD, 0);
		chk("cmd_err", 0, rd);
		for (int i = 0; i < 40; i++) begin
			if (i == 20) begin
				mg = 9;
				apb(1, VTF_ADDR_MGMT, 9);
			end
			rs = lfsr(rs);
			rx(rs % 8, rs[8], rs[20:9], rs[21]);
		end
		for (int p = 0; p < 16; p++)
			tx(p % 8, p / 8);
		apb(1, VTF_ADDR_JOIN, 3);
		apb(1, VTF_ADDR_LEAVEALL, 7);
		apb(1, VTF_ADDR_PORT_BASE + 12'h00C, 32'h0004_0001);
		apb(1, VTF_ADDR_CTRL, 1);
		repeat (16) begin
			@(posedge pclk);
			#1;
			n += gv_join_tick == 8'h08;
			m += gv_leaveall_tick == 8'h08;
		end
		chk("join_tick", 4, n);
		chk("leaveall_tick", 2, m);
		@(posedge pclk);
		gv_valid <= 1;
		@(posedge pclk);
		gv_valid <= 0;
		apb(1, VTF_ADDR_TIDX, 1);
		apb(0, VTF_ADDR_TVID, 0);
		chk("gv_entry", 32'h8002_0005, rd);
		summarize();
	end
endmodule
bind vtf_vlan_tag_port_filter vtf_properties chk_i (.pclk, .presetn, .psel, .penable, .pslverr,
	.rx_valid, .rx_tagged, .rx_vid, .cls_valid, .cls_vid, .cls_push, .tx_valid, .tx_outer,
	.eg_valid, .eg_strip, .eg_tag);
